// ### pmrc_regs.svh
// Purpose: Constants of the power mode and reset controller.
// Assumes: Core clock of 200 MHz, a period of 5 ns.
// Notes:   Times are in ns; cycle counts are derived from them.
`ifndef PMRC_REGS_SVH
`define PMRC_REGS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PMRC_CLK_PERIOD_NS     5
`define PMRC_POWERON_WAKE_NS   200
`define PMRC_CHANNEL_WAKE_NS   100
`define PMRC_LH_QUALIFY_NS     150
`define PMRC_XFER_DELAY_NS     80
`define PMRC_POWERON_WAKE_CYC \
    ((`PMRC_POWERON_WAKE_NS + `PMRC_CLK_PERIOD_NS - 1) / `PMRC_CLK_PERIOD_NS)
`define PMRC_CHANNEL_WAKE_CYC \
    ((`PMRC_CHANNEL_WAKE_NS + `PMRC_CLK_PERIOD_NS - 1) / `PMRC_CLK_PERIOD_NS)
`define PMRC_LH_QUALIFY_CYC \
    ((`PMRC_LH_QUALIFY_NS + `PMRC_CLK_PERIOD_NS - 1) / `PMRC_CLK_PERIOD_NS)
`define PMRC_XFER_DELAY_CYC \
    ((`PMRC_XFER_DELAY_NS + `PMRC_CLK_PERIOD_NS - 1) / `PMRC_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Serial frame layout and reset values
// ----------------------------------------------------------------
`define PMRC_CMD_POS           6
`define PMRC_CMD_WR_MODE       2'h2
`define PMRC_CMD_WR_LATCH      2'h3
`define PMRC_RST_CMD_POS       5
`define PMRC_MUX_DEFAULT       3'h7
`define PMRC_OUTL_DEFAULT      4'h0
`define PMRC_ST_TER_POS        7
`define PMRC_ST_STB_POS        6
`define PMRC_ST_LH_POS         5
`define PMRC_ST_OT_POS         4

`endif

// ### pmrc_pkg.sv
// Purpose: Types shared by the power mode and reset controller.
// Assumes: Nothing beyond the constants header.
// Notes:   Holds the mode state type only.
package pmrc_pkg;
    typedef enum logic [1:0] {
        PMRC_STANDBY = 2'b00,
        PMRC_WAKING  = 2'b01,
        PMRC_ACTIVE  = 2'b10,
        PMRC_LIMP    = 2'b11
    } pmrc_mode_type;
endpackage

// ### pmrc_power_mode_reset_control.sv
// Purpose: Mode tracking and reset control of a serial power switch.
// Assumes: 8-bit serial frames, MSB first, sampled on rising sclk.
// Notes:   The host samples sdo on the falling sclk edge.
//
// Notes on behaviour
// - Logic supply start-up returns every serial register to default.
// - Serial link works whenever the logic supply is in range.
// - First frame after any reset returns diagnosis with error flag 1.
// - Stand-by entered when mux select is 111 and no input pin high.
// - In stand-by all error latches are cleared.
// - Entering stand-by sets the stand-by flag.
// - Stand-by entry keeps serial registers; pin wake resumes them.
// - Any input pin high wakes; stages run without logic supply.
// - First channel on from stand-by waits extra channel wake time.
// - Logic supply off and all pins low returns to stand-by.
// - Qualified limp input wakes after wake time; channels 1-3 follow pins.
// - In limp-home a rising pin edge clears its error latch.
// - Every reset restores registers and clears error flags.
// - Reset turns off latch-driven stages and pin-driven channel 4.
// - During reset only channels 1-3 follow pins; no input mode.
// - Power-on reset releases at threshold; host waits wake time.
// - With a pin or limp input high, power-on keeps protection latches.
// - Soft reset command acts as power-on reset; host waits delay.
// - Limp entry resets write registers and protection, with stage supply.
// - In limp-home reads work but writes are discarded.
// - Diagnosis only in normal or limp with supply; no sensing in limp.
`timescale 1ns/1ps
`include "pmrc_regs.svh"

module pmrc_power_mode_reset_control #(
    parameter int POWERON_WAKE_CYC = `PMRC_POWERON_WAKE_CYC,
    parameter int CHANNEL_WAKE_CYC = `PMRC_CHANNEL_WAKE_CYC,
    parameter int LH_QUALIFY_CYC   = `PMRC_LH_QUALIFY_CYC,
    parameter int XFER_DELAY_CYC   = `PMRC_XFER_DELAY_CYC
) (
    input  wire logic       ref_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       sclk_in,
    input  wire logic       cs_b_in,
    input  wire logic       sdi_in,
    output logic            sdo_out,
    output logic            sdo_oe_out,
    input  wire logic       vdd_ok_in,
    input  wire logic       vs_ok_in,
    input  wire logic [3:0] channel_input_pin_in,
    input  wire logic       limp_home_input_in,
    input  wire logic [3:0] fault_in,
    input  wire logic [3:0] over_temp_in,
    output logic [3:0]      power_stage_on_out,
    output logic            standby_flag_out,
    output logic            diag_enable_out,
    output logic            sense_enable_out,
    output pmrc_pkg::pmrc_mode_type mode_out
);
    import pmrc_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Saturating countdown shared by all interval counters.
    function automatic logic [15:0] dec_sat(input logic [15:0] v);
        dec_sat = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [8:0] pin_s1_r;
    logic [8:0] pin_s2_r;
    logic [3:0] chan_pin;
    logic       lhi_pin;
    logic       vdd_ok;
    logic       vs_ok;
    logic       frame_idle;

    // Pins arrive unrelated to the core clock, so each passes two flops.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_s1_r <= 9'h001;
            pin_s2_r <= 9'h001;
        end else begin
            pin_s1_r <= {channel_input_pin_in, limp_home_input_in,
                         vdd_ok_in, vs_ok_in, 1'b0, cs_b_in};
            pin_s2_r <= pin_s1_r;
        end
    end

    assign chan_pin   = pin_s2_r[8:5];
    assign lhi_pin    = pin_s2_r[4];
    assign vdd_ok     = pin_s2_r[3];
    assign vs_ok      = pin_s2_r[2];
    assign frame_idle = pin_s2_r[0];

    // ------------------------------------------------------------
    // Link domain: serial shifter on the host clock
    // ------------------------------------------------------------
    logic       link_rst_b;
    logic [2:0] bit_cnt_r;
    logic [7:0] tx_r;
    logic [6:0] rx_sh_r;
    logic [7:0] rx_word_r;
    logic       done_tgl_r;
    logic [7:0] snap_r;

    // Chip select ends the frame, so the shifter needs no sclk after it.
    assign link_rst_b = rst_b_in & ~cs_b_in;

    always_ff @(posedge sclk_in or negedge link_rst_b) begin
        if (!link_rst_b) begin
            bit_cnt_r <= 3'h0;
            tx_r      <= 8'h00;
            rx_sh_r   <= 7'h00;
        end else begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            rx_sh_r   <= {rx_sh_r[5:0], sdi_in};
            if (bit_cnt_r == 3'h0) begin
                tx_r <= {snap_r[6:0], 1'b0};
            end else begin
                tx_r <= {tx_r[6:0], 1'b0};
            end
        end
    end

    // The received word is held past the frame until the next one ends.
    always_ff @(posedge sclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_word_r  <= 8'h00;
            done_tgl_r <= 1'b0;
        end else if (!cs_b_in && bit_cnt_r == 3'h7) begin
            rx_word_r  <= {rx_sh_r, sdi_in};
            done_tgl_r <= ~done_tgl_r;
        end
    end

    // The link runs on the logic supply alone.
    assign sdo_out    = (bit_cnt_r == 3'h0) ? snap_r[7] : tx_r[7];
    assign sdo_oe_out = ~cs_b_in & vdd_ok_in;

    // ------------------------------------------------------------
    // Frame completion crossing into the core
    // ------------------------------------------------------------
    logic [2:0] done_sync_r;
    logic       frame_done;

    // Toggle crossing; the word itself is stable for a whole frame.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            done_sync_r <= 3'h0;
        end else begin
            done_sync_r <= {done_sync_r[1:0], done_tgl_r};
        end
    end

    assign frame_done = done_sync_r[2] ^ done_sync_r[1];

    // ------------------------------------------------------------
    // Mode state and interval counters
    // ------------------------------------------------------------
    pmrc_mode_type mode_r;
    pmrc_mode_type mode_nxt;
    logic [3:0]    outl_r;
    logic [2:0]    mux_r;
    logic [15:0]   wake_cnt_r;
    logic [15:0]   lh_cnt_r;
    logic [15:0]   busy_cnt_r;
    logic [15:0]   chw_cnt_r;
    logic          lh_qual;
    logic          mux_dflt;
    logic          sleep_cond;
    logic          soft_rst;
    logic          lh_rst;
    logic          any_rst;
    logic          rst_busy;
    logic          wr_ok;

    assign mux_dflt   = (mux_r == `PMRC_MUX_DEFAULT);
    assign lh_qual    = lhi_pin && (lh_cnt_r == 16'h0000);
    // No logic supply counts as default mux select.
    assign sleep_cond = (mux_dflt || !vdd_ok) && (chan_pin == 4'h0)
                        && !lhi_pin;
    assign rst_busy   = (busy_cnt_r != 16'h0000);
    // Writes are dropped in limp-home and while a reset settles.
    assign wr_ok      = frame_done && (mode_r != PMRC_LIMP) && !rst_busy
                        && rx_word_r[7];
    assign soft_rst   = wr_ok && (rx_word_r[7:6] == `PMRC_CMD_WR_MODE)
                        && rx_word_r[`PMRC_RST_CMD_POS];
    // Limp entry resets the register bank only with stage supply.
    assign lh_rst     = lh_qual && (mode_r != PMRC_LIMP)
                        && vs_ok;
    assign any_rst    = soft_rst || lh_rst;

    // Limp input must stay high for the qualify time.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lh_cnt_r <= 16'(LH_QUALIFY_CYC);
        end else if (!lhi_pin) begin
            lh_cnt_r <= 16'(LH_QUALIFY_CYC);
        end else begin
            lh_cnt_r <= dec_sat(lh_cnt_r);
        end
    end

    // Transfer delay after a reset blocks writes.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            busy_cnt_r <= 16'h0000;
        end else if (any_rst) begin
            busy_cnt_r <= 16'(XFER_DELAY_CYC);
        end else begin
            busy_cnt_r <= dec_sat(busy_cnt_r);
        end
    end

    // Mode transitions.
    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            PMRC_STANDBY: begin
                if (lh_qual || !mux_dflt) begin
                    mode_nxt = PMRC_WAKING;
                end else if (chan_pin != 4'h0) begin
                    mode_nxt = PMRC_ACTIVE;
                end
            end
            PMRC_WAKING: begin
                if (wake_cnt_r == 16'h0000) begin
                    mode_nxt = lhi_pin ? PMRC_LIMP : PMRC_ACTIVE;
                end
            end
            PMRC_ACTIVE: begin
                if (lh_qual) begin
                    mode_nxt = PMRC_LIMP;
                end else if (sleep_cond) begin
                    mode_nxt = PMRC_STANDBY;
                end
            end
            PMRC_LIMP: begin
                if (!lhi_pin) begin
                    mode_nxt = sleep_cond ? PMRC_STANDBY : PMRC_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_r <= PMRC_STANDBY;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Power-on wake time counts down in the waking state.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wake_cnt_r <= 16'h0000;
        end else if (mode_r != PMRC_WAKING) begin
            wake_cnt_r <= 16'(POWERON_WAKE_CYC);
        end else begin
            wake_cnt_r <= dec_sat(wake_cnt_r);
        end
    end

    // ------------------------------------------------------------
    // Serial write registers
    // ------------------------------------------------------------
    // Power-on and every reset trigger restore defaults; stand-by entry
    // does not touch them, so a pin wake keeps the old settings.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mux_r  <= `PMRC_MUX_DEFAULT;
            outl_r <= `PMRC_OUTL_DEFAULT;
        end else if (any_rst) begin
            mux_r  <= `PMRC_MUX_DEFAULT;
            outl_r <= `PMRC_OUTL_DEFAULT;
        end else if (wr_ok && rx_word_r[7:6] == `PMRC_CMD_WR_MODE) begin
            mux_r  <= rx_word_r[2:0];
        end else if (wr_ok && rx_word_r[7:6] == `PMRC_CMD_WR_LATCH) begin
            outl_r <= rx_word_r[3:0];
        end
    end

    // ------------------------------------------------------------
    // Error and protection latches
    // ------------------------------------------------------------
    logic [3:0] err_r;
    logic [3:0] ot_r;
    logic [3:0] pin_d_r;
    logic [1:0] por_cnt_r;
    logic [3:0] pin_rise;

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_d_r <= 4'h0;
        end else begin
            pin_d_r <= chan_pin;
        end
    end

    assign pin_rise = chan_pin & ~pin_d_r;

    // Faults set their latch; a set in the clearing cycle still wins.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            err_r <= 4'h0;
        end else if (mode_r == PMRC_STANDBY || any_rst) begin
            err_r <= fault_in;
        end else if (mode_r == PMRC_LIMP) begin
            err_r <= (err_r & ~pin_rise) | fault_in;
        end else begin
            err_r <= err_r | fault_in;
        end
    end

    // Settle count so the synchronised pins are valid at the check.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            por_cnt_r <= 2'h3;
        end else if (por_cnt_r != 2'h0) begin
            por_cnt_r <= por_cnt_r - 2'h1;
        end
    end

    // Protection latches ride through power-on while a pin is high, so
    // they carry no asynchronous reset and are cleared after release.
    always_ff @(posedge ref_clk_in) begin
        if (por_cnt_r == 2'h1 && chan_pin == 4'h0 && !lhi_pin) begin
            ot_r <= over_temp_in;
        end else if (any_rst) begin
            ot_r <= over_temp_in;
        end else begin
            ot_r <= ot_r | over_temp_in;
        end
    end

    // ------------------------------------------------------------
    // Stand-by flag and transfer error flag
    // ------------------------------------------------------------
    logic stb_r;
    logic ter_r;

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            stb_r <= 1'b0;
        end else if (mode_nxt == PMRC_STANDBY && mode_r != PMRC_STANDBY) begin
            stb_r <= 1'b1;
        end else if (mode_r != PMRC_STANDBY) begin
            stb_r <= 1'b0;
        end
    end

    // A reset in the same cycle as a frame end keeps the flag set.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ter_r <= 1'b1;
        end else if (any_rst) begin
            ter_r <= 1'b1;
        end else if (frame_done) begin
            ter_r <= 1'b0;
        end
    end

    // Read snapshot only changes between frames, so the link can read it
    // at its first edge; a frame starting within 10 ns of an update races.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            snap_r <= 8'h80;
        end else if (frame_idle) begin
            snap_r <= {ter_r, stb_r, mode_r == PMRC_LIMP, |ot_r, err_r};
        end
    end

    // ------------------------------------------------------------
    // Power stage drive
    // ------------------------------------------------------------
    logic [3:0] want;
    logic [3:0] stage_r;
    logic       any_on;
    logic       limited;

    // Limp-home and reset both restrict pins to channels 1 to 3 and
    // drop the latch bits.
    assign limited = (mode_r == PMRC_LIMP) || rst_busy;
    assign want    = limited ? {1'b0, chan_pin[2:0]}
                             : (chan_pin | (vdd_ok ? outl_r : 4'h0));
    assign any_on  = (stage_r != 4'h0);

    // First channel out of idle waits the channel wake time.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            chw_cnt_r <= 16'(CHANNEL_WAKE_CYC);
        end else if (any_on || want == 4'h0) begin
            chw_cnt_r <= 16'(CHANNEL_WAKE_CYC);
        end else begin
            chw_cnt_r <= dec_sat(chw_cnt_r);
        end
    end

    // Pins drive stages without the logic supply.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            stage_r <= 4'h0;
        end else if (any_on || chw_cnt_r == 16'h0000) begin
            stage_r <= want & ~ot_r;
        end else begin
            stage_r <= 4'h0;
        end
    end

    assign power_stage_on_out = stage_r;
    assign standby_flag_out   = stb_r;
    assign mode_out           = mode_r;
    assign diag_enable_out    = vdd_ok && (mode_r == PMRC_ACTIVE
                                || mode_r == PMRC_LIMP);
    assign sense_enable_out   = vdd_ok && (mode_r == PMRC_ACTIVE);
endmodule

// ### pmrc_asserts.sv
// Purpose: Port-level checks of the mode and reset controller.
// Assumes: One core clock domain; sees only the top module's ports.
// Notes:   The waking interval is measured by a helper counter.
`timescale 1ns/1ps

module pmrc_asserts #(
    parameter int POWERON_WAKE_CYC = 40
) (
    input wire logic                    ref_clk_in,
    input wire logic                    rst_b_in,
    input wire logic                    cs_b_in,
    input wire logic                    vdd_ok_in,
    input wire logic [3:0]              channel_input_pin_in,
    input wire logic                    sdo_oe_out,
    input wire logic [3:0]              power_stage_on_out,
    input wire logic                    standby_flag_out,
    input wire logic                    diag_enable_out,
    input wire logic                    sense_enable_out,
    input wire pmrc_pkg::pmrc_mode_type mode_out
);
    import pmrc_pkg::*;

    logic [7:0] wake_cnt_r;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);

    // Counts cycles spent waking, so a stuck or short wait is caught.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wake_cnt_r <= 8'h00;
        end else if (mode_out == PMRC_WAKING) begin
            wake_cnt_r <= wake_cnt_r + 8'h01;
        end else begin
            wake_cnt_r <= 8'h00;
        end
    end

    a_reset_idle: assert property ($rose(rst_b_in) |->
        mode_out == PMRC_STANDBY && power_stage_on_out == 4'h0)
        else $error("outputs not idle after reset");
    a_oe_follow: assert property (
        sdo_oe_out == (!cs_b_in && vdd_ok_in))
        else $error("serial output enable wrong");
    a_wake_len: assert property (mode_out != PMRC_WAKING &&
        $past(mode_out) == PMRC_WAKING
        |-> int'(wake_cnt_r) == POWERON_WAKE_CYC + 1)
        else $error("waking interval has wrong length");
    a_wake_bound: assert property (mode_out == PMRC_WAKING |->
        int'(wake_cnt_r) <= POWERON_WAKE_CYC)
        else $error("waking lasts too long");
    a_pin_wake: assert property (mode_out == PMRC_STANDBY &&
        channel_input_pin_in != 4'h0 |-> ##[1:6] mode_out != PMRC_STANDBY)
        else $error("input pin did not wake the device");
    a_stb_entry: assert property (mode_out == PMRC_STANDBY &&
        $past(mode_out) == PMRC_ACTIVE |-> ##[0:2] standby_flag_out)
        else $error("stand-by flag not set on entry");
    a_limp_ch4: assert property (mode_out == PMRC_LIMP &&
        $past(mode_out) == PMRC_LIMP |-> !power_stage_on_out[3])
        else $error("fourth stage on in limp-home");
    a_limp_sense: assert property (
        mode_out == PMRC_LIMP |-> !sense_enable_out)
        else $error("current sense on in limp-home");
    a_diag_mode: assert property (diag_enable_out |->
        mode_out == PMRC_ACTIVE || mode_out == PMRC_LIMP)
        else $error("diagnosis enabled in wrong mode");
endmodule

// ### pmrc_host_model.sv
// Purpose: Serial host on the far side of the controller.
// Assumes: 8-bit frames, MSB first, sdo read on falling sclk.
// Notes:   Clock stands low between frames; sdi shows junk then.
`timescale 1ns/1ps

module pmrc_host_model #(
    parameter int HALF_NS = 24
) (
    output logic      sclk_out,
    output logic      cs_b_out,
    output logic      sdi_out,
    input  wire logic sdo_in
);
    // Idle levels before the first frame.
    initial begin
        sclk_out = 1'h0;
        cs_b_out = 1'h1;
        sdi_out  = 1'h0;
    end

    // One whole frame; the odd start offset keeps phase unrelated.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        #7;
        cs_b_out = 1'h0;
        #HALF_NS;
        rx[7] = sdo_in;
        for (int i = 7; i >= 0; i--) begin
            sdi_out = tx[i];
            #HALF_NS;
            sclk_out = 1'h1;
            #HALF_NS;
            sclk_out = 1'h0;
            if (i > 0) begin
                rx[i - 1] = sdo_in;
            end
        end
        #HALF_NS;
        cs_b_out = 1'h1;
        sdi_out  = ~sdi_out;
    endtask
endmodule

// ### tb_pmrc.sv
// Purpose: Self-checking bench of the mode and reset controller.
// Assumes: Short interval parameters so the run stays brief.
// Notes:   Frames go through the host model's transfer task.
`timescale 1ns/1ps

module tb;
    import pmrc_pkg::*;

    localparam int PW = 4;
    localparam int CW = 8;
    localparam int LQ = 6;
    localparam int XD = 4;

    logic          ref_clk_in;
    logic          rst_b_in;
    logic          sclk;
    logic          cs_b;
    logic          sdi;
    logic          sdo;
    logic          sdo_oe;
    logic          vdd_ok;
    logic [3:0]    pins;
    logic          limp;
    logic [3:0]    fault;
    logic [3:0]    ot;
    logic [3:0]    stages;
    logic          stb;
    logic          diag;
    logic          sense;
    pmrc_mode_type mode;
    logic [7:0]    st;
    int            bad_count;
    int            check_count;
    int            cycle_count;

    pmrc_power_mode_reset_control #(.POWERON_WAKE_CYC(PW),
        .CHANNEL_WAKE_CYC(CW), .LH_QUALIFY_CYC(LQ), .XFER_DELAY_CYC(XD)
    ) i_pmrc_power_mode_reset_control (.ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in), .sclk_in(sclk), .cs_b_in(cs_b),
        .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
        .vdd_ok_in(vdd_ok), .vs_ok_in(1'h1), .channel_input_pin_in(pins),
        .limp_home_input_in(limp), .fault_in(fault), .over_temp_in(ot),
        .power_stage_on_out(stages), .standby_flag_out(stb),
        .diag_enable_out(diag), .sense_enable_out(sense), .mode_out(mode));

    pmrc_host_model i_pmrc_host_model (.sclk_out(sclk), .cs_b_out(cs_b),
        .sdi_out(sdi), .sdo_in(sdo));

    // Core clock of 5 ns.
    initial begin
        ref_clk_in = 1'h0;
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask

    // A frame, then room for the core to act on it.
    task automatic frame(input logic [7:0] tx);
        i_pmrc_host_model.xfer(tx, st);
        cyc(20);
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_mode(input pmrc_mode_type exp);
        check_count++;
        if (mode !== exp) begin
            bad_count++;
            $display("mismatch mode expected %0d seen %0d", exp, mode);
        end
    endtask

    // One-cycle error and over-temperature events.
    task automatic events(input logic [3:0] f, input logic [3:0] o);
        @(posedge ref_clk_in) fault <= f;
        ot <= o;
        @(posedge ref_clk_in) fault <= 4'h0;
        ot <= 4'h0;
        cyc(4);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Cuts a hang short.
    always @(posedge ref_clk_in) begin
        cycle_count++;
        if (cycle_count == 20000) begin
            bad_count++;
            final_report();
        end
    end

    // Main sequence.
    initial begin
        rst_b_in = 1'h0;
        vdd_ok = 1'h1;
        pins = 4'h0;
        limp = 1'h0;
        fault = 4'h0;
        ot = 4'h0;
        cyc(2);
        @(posedge ref_clk_in) rst_b_in <= 1'h1;
        cyc(6);
        chk_mode(PMRC_STANDBY);
        chk("stages", 8'h00, {4'h0, stages});
        frame(8'h00);
        chk("ter", 8'h01, {7'h0, st[7]});
        frame(8'h00);
        chk("ter", 8'h00, {7'h0, st[7]});
        $display("test reset done");
        for (int m = 0; m < 7; m++) begin
            frame(8'h80 | 8'(m));
            chk_mode(PMRC_ACTIVE);
            chk("diag", 8'h01, {7'h0, diag});
            frame(8'h87);
            chk_mode(PMRC_STANDBY);
            chk("stb", 8'h01, {7'h0, stb});
        end
        $display("test wake done");
        frame(8'h81);
        frame(8'hC5);
        chk("stages", 8'h05, {4'h0, stages});
        events(4'h1, 4'h4);
        frame(8'h00);
        chk("flags", 8'h11, {3'h0, st[4:0]});
        frame(8'hA0);
        cyc(XD + 4);
        chk("stages", 8'h00, {4'h0, stages});
        chk_mode(PMRC_STANDBY);
        frame(8'h00);
        chk("ter", 8'h01, {7'h0, st[7]});
        chk("flags", 8'h00, {3'h0, st[4:0]});
        $display("test soft reset done");
        frame(8'h81);
        frame(8'hC2);
        events(4'h1, 4'h0);
        frame(8'h87);
        chk_mode(PMRC_STANDBY);
        frame(8'h00);
        chk("err", 8'h00, {4'h0, st[3:0]});
        @(posedge ref_clk_in) pins <= 4'h1;
        cyc(CW + 12);
        chk("stages", 8'h03, {4'h0, stages});
        frame(8'hA0);
        cyc(XD + 4);
        chk("stages", 8'h01, {4'h0, stages});
        $display("test resume done");
        events(4'h0, 4'h1);
        @(posedge ref_clk_in) rst_b_in <= 1'h0;
        cyc(2);
        @(posedge ref_clk_in) rst_b_in <= 1'h1;
        cyc(6);
        frame(8'h00);
        chk("ter", 8'h01, {7'h0, st[7]});
        chk("ot", 8'h01, {7'h0, st[4]});
        @(posedge ref_clk_in) pins <= 4'h0;
        cyc(12);
        @(posedge ref_clk_in) vdd_ok <= 1'h0;
        pins <= 4'h2;
        cyc(CW);
        chk("stages", 8'h00, {4'h0, stages});
        cyc(12);
        chk("stages", 8'h02, {4'h0, stages});
        chk_mode(PMRC_ACTIVE);
        @(posedge ref_clk_in) pins <= 4'h0;
        cyc(8);
        chk_mode(PMRC_STANDBY);
        @(posedge ref_clk_in) vdd_ok <= 1'h1;
        cyc(6);
        $display("test pins done");
        frame(8'h81);
        events(4'h0, 4'h8);
        @(posedge ref_clk_in) limp <= 1'h1;
        cyc(LQ + PW + 12);
        chk_mode(PMRC_LIMP);
        chk("sense", 8'h00, {7'h0, sense});
        chk("diag", 8'h01, {7'h0, diag});
        frame(8'hC1);
        chk("stages", 8'h00, {4'h0, stages});
        events(4'h2, 4'h0);
        frame(8'h00);
        chk("lh", 8'h01, {7'h0, st[5]});
        chk("ot", 8'h00, {7'h0, st[4]});
        chk("err", 8'h02, {4'h0, st[3:0]});
        @(posedge ref_clk_in) pins <= 4'hF;
        cyc(CW + 12);
        chk("stages", 8'h07, {4'h0, stages});
        frame(8'h00);
        chk("err", 8'h00, {4'h0, st[3:0]});
        @(posedge ref_clk_in) limp <= 1'h0;
        pins <= 4'h0;
        cyc(12);
        chk("stages", 8'h00, {4'h0, stages});
        chk_mode(PMRC_STANDBY);
        $display("test limp done");
        final_report();
    end
endmodule

bind pmrc_power_mode_reset_control pmrc_asserts #(
    .POWERON_WAKE_CYC(POWERON_WAKE_CYC)
) i_pmrc_asserts (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .cs_b_in(cs_b_in), .vdd_ok_in(vdd_ok_in),
    .channel_input_pin_in(channel_input_pin_in), .sdo_oe_out(sdo_oe_out),
    .power_stage_on_out(power_stage_on_out),
    .standby_flag_out(standby_flag_out), .diag_enable_out(diag_enable_out),
    .sense_enable_out(sense_enable_out), .mode_out(mode_out));
